/* File: mps_pkg.sv */
// Constants and types shared by the module power sequencer.
`default_nettype none
package mps_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned RAMP_HOLD_MS  = 100;
  localparam int unsigned RAMP_MIN_MS   = 10;
  localparam int unsigned RST_STRETCH_MS = 1;
  localparam int unsigned RAMP_HOLD_CYC =
    (CLK_HZ / 1000) * RAMP_HOLD_MS;
  localparam int unsigned RST_STRETCH_CYC =
    (CLK_HZ / 1000) * RST_STRETCH_MS;
  localparam int unsigned CNT_W         = 22;

  typedef enum logic [2:0] {
    MPS_UNPLUGGED,
    MPS_RAIL_WAIT,
    MPS_RAMP,
    MPS_RUN,
    MPS_SLEEP_WAIT,
    MPS_RESET,
    MPS_STRETCH,
    MPS_OFF
  } mps_state_e;
endpackage
`default_nettype wire

/* File: mps_sync.sv */
// Two-stage synchroniser for a group of asynchronous level inputs.
`timescale 1ns/1ps
`default_nettype none
module mps_sync #(
  parameter int unsigned WIDTH = 2,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = i_async;
    sync_nxt = meta_r;
    if (!i_reset_n) begin
      meta_nxt = INIT;
      sync_nxt = INIT;
    end
  end

  always_ff @(posedge i_core_clk) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  assign o_sync = sync_r;
endmodule
`default_nettype wire

/* File: mps_top.sv */
// Power-state sequencer for a plug-in module and its carrier board.
//
// Function
// - Module supplies stay off while the input power fault line is low, and the on-module controller starts when it reads high.
// - Carrier power enable rises only once main supply is present and all boot supplies report ready.
// - Carrier reset stays asserted for at least 10 ms after carrier power enable rises.
// - Carrier reset is not released until at least 100 ms after carrier power enable rose.
// - The running state is entered automatically after the power-up handshake, with no request.
// - A software suspend request in running moves to suspend, and a wakeup returns to running.
// - A software shutdown request in running turns off module rails and carrier power enable, entering off; a same-cycle reset request wins and keeps both on.
// - From off, running resumes after main supply is removed and reapplied, or on a reset request pulse.
// - While the reset request is low, rails stay powered and processor and peripherals are held in reset.
// - Internal reset and carrier reset are asserted for as long as the reset request is asserted.
// - After the reset request is released, both resets stay low at least 1 ms more before booting.
`timescale 1ns/1ps
`default_nettype none
module mps_top
  import mps_pkg::*;
#(
  parameter int unsigned RAMP_CYC    = RAMP_HOLD_CYC,
  parameter int unsigned STRETCH_CYC = RST_STRETCH_CYC
) (
  input  wire logic i_core_clk,
  input  wire logic i_reset_n,
  input  wire logic i_input_power_fault_n,
  input  wire logic i_reset_request_n,
  input  wire logic i_rails_ready,
  input  wire logic i_suspend_req,
  input  wire logic i_shutdown_req,
  input  wire logic i_wakeup,
  output logic      o_module_rails_en,
  output logic      o_carrier_power_enable,
  output logic      o_carrier_reset_n,
  output logic      o_core_reset_n,
  output logic      o_cpu_halt,
  output logic [2:0] o_state
);

  initial begin
    if (RAMP_CYC < 1 || RAMP_CYC >= (1 << CNT_W) ||
        STRETCH_CYC < 1 || STRETCH_CYC >= (1 << CNT_W))
      $error("mps_top: count parameters out of range");
  end

  ////////////////////////////////////////////////////////////////////////////

  logic [1:0] pin_sync;
  logic       pwr_good;
  logic       rst_req;

  mps_sync #(
    .WIDTH (2),
    .INIT  (2'h0)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_async    ({i_input_power_fault_n, i_reset_request_n}),
    .o_sync     (pin_sync)
  );

  assign pwr_good = pin_sync[1];
  assign rst_req  = ~pin_sync[0];

  ////////////////////////////////////////////////////////////////////////////

  mps_state_e       state_r;
  mps_state_e       state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             rails_r;
  logic             rails_nxt;
  logic             cpe_r;
  logic             cpe_nxt;
  logic             crst_n_r;
  logic             crst_n_nxt;
  logic             irst_n_r;
  logic             irst_n_nxt;
  logic             halt_r;
  logic             halt_nxt;

  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    rails_nxt  = rails_r;
    cpe_nxt    = cpe_r;
    crst_n_nxt = crst_n_r;
    irst_n_nxt = irst_n_r;
    halt_nxt   = halt_r;
    case (state_r)
      // supplies held off while power is bad
      MPS_UNPLUGGED: begin
        rails_nxt  = 1'b0;
        cpe_nxt    = 1'b0;
        crst_n_nxt = 1'b0;
        irst_n_nxt = 1'b0;
        halt_nxt   = 1'b0;
        if (pwr_good) begin
          rails_nxt = 1'b1;
          state_nxt = MPS_RAIL_WAIT;
        end
      end
      // enable carrier once boot rails ready
      MPS_RAIL_WAIT: begin
        if (i_rails_ready) begin
          cpe_nxt   = 1'b1;
          cnt_nxt   = '0;
          state_nxt = MPS_RAMP;
        end
      end
      // hold carrier reset for the ramp time
      MPS_RAMP: begin
        if (cnt_r == CNT_W'(RAMP_CYC - 1)) begin
          state_nxt = MPS_STRETCH;
          cnt_nxt   = '0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      MPS_RUN: begin
        if (i_shutdown_req) begin
          // shutdown drops rails and carrier enable
          rails_nxt  = 1'b0;
          cpe_nxt    = 1'b0;
          crst_n_nxt = 1'b0;
          irst_n_nxt = 1'b0;
          state_nxt  = MPS_OFF;
        end else if (i_suspend_req) begin
          halt_nxt  = 1'b1;
          state_nxt = MPS_SLEEP_WAIT;
        end
      end
      MPS_SLEEP_WAIT: begin
        if (i_wakeup) begin
          halt_nxt  = 1'b0;
          state_nxt = MPS_RUN;
        end
      end
      MPS_RESET: begin
        crst_n_nxt = 1'b0;
        irst_n_nxt = 1'b0;
        halt_nxt   = 1'b0;
        cnt_nxt    = '0;
        if (!rst_req) begin
          state_nxt = MPS_STRETCH;
        end
      end
      MPS_STRETCH: begin
        if (cnt_r == CNT_W'(STRETCH_CYC - 1)) begin
          crst_n_nxt = 1'b1;
          irst_n_nxt = 1'b1;
          state_nxt  = MPS_RUN;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      MPS_OFF: begin
        if (rst_req) begin
          rails_nxt = 1'b1;
          state_nxt = MPS_RAIL_WAIT;
        end
      end
      default: begin
        state_nxt = MPS_UNPLUGGED;
      end
    endcase
    // reset request overrides carrier-powered states except ramp.
    // A shutdown in the same cycle loses, so the rails stay up in reset.
    if (rst_req && cpe_r && state_r != MPS_RAMP &&
        state_r != MPS_OFF) begin
      rails_nxt  = rails_r;
      cpe_nxt    = cpe_r;
      crst_n_nxt = 1'b0;
      irst_n_nxt = 1'b0;
      halt_nxt   = 1'b0;
      state_nxt  = MPS_RESET;
    end
    // loss of main supply forces everything off
    if (!pwr_good) begin
      rails_nxt  = 1'b0;
      cpe_nxt    = 1'b0;
      crst_n_nxt = 1'b0;
      irst_n_nxt = 1'b0;
      halt_nxt   = 1'b0;
      state_nxt  = MPS_UNPLUGGED;
    end
    if (!i_reset_n) begin
      state_nxt  = MPS_UNPLUGGED;
      cnt_nxt    = '0;
      rails_nxt  = 1'b0;
      cpe_nxt    = 1'b0;
      crst_n_nxt = 1'b0;
      irst_n_nxt = 1'b0;
      halt_nxt   = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    state_r  <= state_nxt;
    cnt_r    <= cnt_nxt;
    rails_r  <= rails_nxt;
    cpe_r    <= cpe_nxt;
    crst_n_r <= crst_n_nxt;
    irst_n_r <= irst_n_nxt;
    halt_r   <= halt_nxt;
  end

  assign o_module_rails_en      = rails_r;
  assign o_carrier_power_enable = cpe_r;
  assign o_carrier_reset_n      = crst_n_r;
  assign o_core_reset_n         = irst_n_r;
  assign o_cpu_halt             = halt_r;
  assign o_state                = state_r;

endmodule
`default_nettype wire

/* File: mps_top_asserts.sv */
// Port assertions for the module power sequencer.
`timescale 1ns/1ps
`default_nettype none
module mps_top_asserts #(
  parameter int unsigned RAMP_CYC    = 8,
  parameter int unsigned STRETCH_CYC = 4
) (
  input wire logic       i_core_clk,
  input wire logic       i_reset_n,
  input wire logic       i_input_power_fault_n,
  input wire logic       i_reset_request_n,
  input wire logic       i_rails_ready,
  input wire logic       i_shutdown_req,
  input wire logic       o_module_rails_en,
  input wire logic       o_carrier_power_enable,
  input wire logic       o_carrier_reset_n,
  input wire logic       o_core_reset_n,
  input wire logic [2:0] o_state
);
  localparam int HOLD = RAMP_CYC + STRETCH_CYC;
  logic [31:0] up_r;
  logic [31:0] up_nxt;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // Saturates so that a long run never wraps back under the hold figure.
  always_comb up_nxt = o_carrier_power_enable ?
    up_r + {31'h0, ~&up_r} : 32'h0;
  always_ff @(posedge i_core_clk) up_r <= up_nxt;
  sequence req_held_s;
    !i_reset_request_n [*3];
  endsequence
  a_fault_off: assert property (!i_input_power_fault_n [*3] |=>
    !o_module_rails_en && !o_carrier_power_enable)
    else $error("rails on during fault");
  a_cpe_ready: assert property ($rose(o_carrier_power_enable) |->
    $past(i_rails_ready) && o_module_rails_en)
    else $error("enable without ready");
  a_ramp_hold: assert property ($rose(o_carrier_reset_n) |->
    up_r >= HOLD)
    else $error("carrier reset released early");
  a_run_released: assert property (o_state == 3'h3 |->
    o_core_reset_n && o_carrier_reset_n && o_module_rails_en)
    else $error("run state not released");
  a_shutdown_off: assert property (o_state == 3'h3 && i_shutdown_req |=>
    !o_module_rails_en && !o_carrier_power_enable)
    else $error("shutdown left power on");
  a_req_resets: assert property (req_held_s ##0 o_state == 3'h3 |=>
    !o_core_reset_n && !o_carrier_reset_n)
    else $error("reset request not obeyed");
  a_reset_powered: assert property (o_state == 3'h5 |->
    o_module_rails_en && o_carrier_power_enable && !o_core_reset_n)
    else $error("reset state not powered");
  a_stretch_len: assert property ($rose(o_core_reset_n) |->
    $past(o_state, STRETCH_CYC) == 3'h6)
    else $error("reset stretch too short");
endmodule
`default_nettype wire

/* File: mps_carrier.sv */
// Carrier board model: supply detector, rail ramp and reset release.
`timescale 1ns/1ps
`default_nettype none
module mps_carrier (
  input  wire logic i_core_clk,
  input  wire logic i_mains,
  input  wire logic i_button,
  input  wire logic i_cpe,
  output logic      o_fault_n,
  output logic      o_req_n
);
  logic [2:0] rail_r;
  always_ff @(posedge i_core_clk) rail_r <= i_cpe ? {rail_r[1:0], 1'h1} : 3'h0;
  assign o_fault_n = i_mains;
  // release after rails ready
  // Unpowered reset logic floats, so the pulled-up line reads high.
  assign o_req_n = !i_button && (rail_r[2] || !i_cpe);
endmodule
`default_nettype wire

/* File: mps_top_bench.sv */
// Self-checking bench for the module power sequencer.
`timescale 1ns/1ps
`default_nettype none
module mps_top_bench;
  import mps_pkg::*;
  localparam int unsigned RAMP_CYC    = 8;
  localparam int unsigned STRETCH_CYC = 4;
  logic       clk = 1'h0, rst_n = 1'h0, mains = 1'h0, button = 1'h0;
  logic       ready = 1'h0, susp = 1'h0, shut = 1'h0, wake = 1'h0;
  logic       fault_n, req_n, rails, cpe, crst_n, core_n, halt;
  logic [2:0] st;
  int         num_errors = 0, comparisons = 0, n;
  always #25 clk = ~clk;
  mps_carrier carrier (.i_core_clk(clk), .i_mains(mains), .i_button(button),
    .i_cpe(cpe), .o_fault_n(fault_n), .o_req_n(req_n));
  mps_top #(.RAMP_CYC(RAMP_CYC), .STRETCH_CYC(STRETCH_CYC)) dut (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_input_power_fault_n(fault_n),
    .i_reset_request_n(req_n), .i_rails_ready(ready), .i_suspend_req(susp),
    .i_shutdown_req(shut), .i_wakeup(wake), .o_module_rails_en(rails),
    .o_carrier_power_enable(cpe), .o_carrier_reset_n(crst_n),
    .o_core_reset_n(core_n), .o_cpu_halt(halt), .o_state(st));
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic wait_state(input logic [2:0] s);
    n = 0;
    while (st !== s) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 500) begin
        num_errors++;
        give_verdict();
      end
    end
  endtask
  task automatic pulse_shutdown;
    @(posedge clk) shut <= 1'h1;
    @(posedge clk) shut <= 1'h0;
    #1;
  endtask
  initial begin
    repeat (1) @(posedge clk);
    @(posedge clk) rst_n <= 1'h1;
    @(posedge clk) mains <= 1'h1;
    wait_state(3'h1);
    repeat (3) @(posedge clk);
    #1;
    check({rails, cpe}, 8'h02);
    @(posedge clk) ready <= 1'h1;
    wait_state(3'h2);
    wait_state(3'h3);
    check(8'(n), 8'(RAMP_CYC + STRETCH_CYC));
    check({crst_n, core_n}, 8'h03);
    @(posedge clk) susp <= 1'h1;
    @(posedge clk) susp <= 1'h0;
    @(posedge clk) #1;
    check({st, halt, cpe}, 8'h13);
    @(posedge clk) wake <= 1'h1;
    @(posedge clk) wake <= 1'h0;
    @(posedge clk) #1;
    check({st, halt}, 8'h06);
    @(posedge clk) button <= 1'h1;
    repeat (5) @(posedge clk);
    #1;
    check({st, rails, cpe, crst_n, core_n}, 8'h5C);
    @(posedge clk) button <= 1'h0;
    wait_state(3'h6);
    wait_state(3'h3);
    check(8'(n), 8'(STRETCH_CYC));
    pulse_shutdown();
    @(posedge clk) #1;
    check({st, rails, cpe, core_n}, 8'h38);
    @(posedge clk) button <= 1'h1;
    wait_state(3'h1);
    check(rails, 8'h01);
    @(posedge clk) button <= 1'h0;
    wait_state(3'h3);
    pulse_shutdown();
    @(posedge clk) mains <= 1'h0;
    wait_state(3'h0);
    check({rails, cpe, crst_n, core_n, halt}, 8'h00);
    @(posedge clk) mains <= 1'h1;
    wait_state(3'h3);
    check(crst_n, 8'h01);
    @(posedge clk) mains <= 1'h0;
    wait_state(3'h0);
    check({rails, cpe, crst_n, core_n, halt}, 8'h00);
    give_verdict();
  end
endmodule
bind mps_top mps_top_asserts #(.RAMP_CYC(RAMP_CYC),
  .STRETCH_CYC(STRETCH_CYC)) u_chk (.i_core_clk(i_core_clk),
  .i_reset_n(i_reset_n), .i_input_power_fault_n(i_input_power_fault_n),
  .i_reset_request_n(i_reset_request_n), .i_rails_ready(i_rails_ready),
  .i_shutdown_req(i_shutdown_req), .o_module_rails_en(o_module_rails_en),
  .o_carrier_power_enable(o_carrier_power_enable),
  .o_carrier_reset_n(o_carrier_reset_n), .o_core_reset_n(o_core_reset_n),
  .o_state(o_state));
`default_nettype wire
